/* vust_cfg.svh */
// constants for the vector upper state tracker
`ifndef VUST_CFG_SVH
`define VUST_CFG_SVH
`define VUST_NUM_REGS 16
`define VUST_HALF_W 128
`define VUST_ELEM_W 32
`define VUST_SEL_W 2
`define VUST_IMM_W 8
`define VUST_ELEMS_PER_LANE 4
`define VUST_SAVE_CYCLES 8
`define VUST_RESTORE_CYCLES 8
`endif

/* vust_pkg.sv */
// types shared by the vector upper state tracker
package vust_pkg;
  // upper-half tracking states
  typedef enum logic [1:0] {
    VUST_CLEAN,
    VUST_DIRTY,
    VUST_SAVED
  } vust_state_e;
  // instruction class presented by issue logic
  typedef enum logic [2:0] {
    VUST_OP_NONE,
    VUST_OP_LEGACY,
    VUST_OP_EXT128,
    VUST_OP_EXT256,
    VUST_OP_ZEROUP,
    VUST_OP_XSTATE
  } vust_op_e;
endpackage : vust_pkg

/* vust_lane_shuffle.sv */
// one 128-bit lane of the in-lane element shuffle
`timescale 1ns/1ps
`include "vust_cfg.svh"
module vust_lane_shuffle #(
  parameter int ELEM_W = `VUST_ELEM_W
) (
  input wire logic [4*ELEM_W-1:0] srcA, // first source lane
  input wire logic [4*ELEM_W-1:0] srcB, // second source lane
  input wire logic [`VUST_IMM_W-1:0] shuffleImmediate, // four 2-bit selectors
  output logic [4*ELEM_W-1:0] result // shuffled lane
);
  // selectors pick only from this lane's elements
  wire [1:0] sel0 = shuffleImmediate[1:0];
  wire [1:0] sel1 = shuffleImmediate[3:2];
  wire [1:0] sel2 = shuffleImmediate[5:4];
  wire [1:0] sel3 = shuffleImmediate[7:6];
  // low two elements come from the first source, upper two from the second
  assign result[ELEM_W-1:0] = srcA[sel0*ELEM_W +: ELEM_W];
  assign result[2*ELEM_W-1:ELEM_W] = srcA[sel1*ELEM_W +: ELEM_W];
  assign result[3*ELEM_W-1:2*ELEM_W] = srcB[sel2*ELEM_W +: ELEM_W];
  assign result[4*ELEM_W-1:3*ELEM_W] = srcB[sel3*ELEM_W +: ELEM_W];
endmodule : vust_lane_shuffle

/* vust_tracker.sv */
// upper-half state tracker with save/restore and lane shuffle
// Behaviour
// - reset gives Clean state, uppers zero
// - legacy keeps uppers; extended writes destination upper
// - extended 128-bit zeroes destination upper, no penalty from Clean/dirty
// - 256-bit from Clean/dirty goes dirty, no penalty
// - legacy in dirty saves uppers, penalty, saved
// - saved: legacy stays; extended restores, penalty, dirty
// - extended 128-bit from Clean/dirty goes Clean
// - legacy in Clean stays Clean, no penalty
// - upper-clear zeroes all uppers, enters Clean
// - upper-clear completes with zero latency
// - state save/restore marks uppers saved-modified
// - 256-bit work runs as two lanes
// - one selector byte drives both lanes
// - selector picks element within its lane
`timescale 1ns/1ps
`include "vust_cfg.svh"
module vust_tracker #(
  parameter int NUM_REGS = `VUST_NUM_REGS,
  parameter int HALF_W = `VUST_HALF_W,
  parameter int SAVE_CYCLES = `VUST_SAVE_CYCLES,
  parameter int RESTORE_CYCLES = `VUST_RESTORE_CYCLES
) (
  input wire logic clock, // core clock
  input wire logic reset, // async reset, active high
  input wire logic opValid, // instruction issued this cycle
  input wire vust_pkg::vust_op_e opClass, // instruction class
  input wire logic [$clog2(NUM_REGS)-1:0] opDest, // destination register
  input wire logic [HALF_W-1:0] opUpperData, // upper result of a 256-bit op
  input wire logic [$clog2(NUM_REGS)-1:0] rdIndex, // upper read index
  input wire logic shufValid, // shuffle request
  input wire logic [2*HALF_W-1:0] shufSrcA, // shuffle first source
  input wire logic [2*HALF_W-1:0] shufSrcB, // shuffle second source
  input wire logic [`VUST_IMM_W-1:0] shuffleImmediate, // selector byte
  output logic opReady, // tracker can take an instruction
  output logic penalty, // one-cycle pulse: save or restore finished
  output logic savePenalty, // one-cycle pulse: it was a save
  output vust_pkg::vust_state_e upperState, // current tracking state
  output logic [HALF_W-1:0] rdUpper, // registered upper half of rdIndex
  output logic shufDone, // shuffle result valid
  output logic [2*HALF_W-1:0] shufResult // registered shuffle result
);
  localparam int IDX_W = $clog2(NUM_REGS);
  localparam int CNT_W = $clog2(SAVE_CYCLES + RESTORE_CYCLES + 1);
  // the counter is sized generously; a move never loads more than one of the two counts

  // live upper halves and the saved image
  logic [HALF_W-1:0] upperHalf [NUM_REGS];
  logic [HALF_W-1:0] savedHalf [NUM_REGS];
  logic [CNT_W-1:0] busyCount; // remaining save/restore cycles
  logic busySave; // busy with a save rather than a restore
  vust_pkg::vust_op_e heldOp; // instruction waiting for the restore
  logic [IDX_W-1:0] heldDest; // its destination
  logic [HALF_W-1:0] heldData; // its upper data
  vust_pkg::vust_state_e next_state;

  // decode of the issued instruction
  wire accept = opValid && opReady;
  wire isLegacy = opClass == vust_pkg::VUST_OP_LEGACY;
  wire isExt128 = opClass == vust_pkg::VUST_OP_EXT128;
  wire isExt256 = opClass == vust_pkg::VUST_OP_EXT256;
  wire isExt = isExt128 || isExt256;
  wire isZero = opClass == vust_pkg::VUST_OP_ZEROUP;
  wire isXstate = opClass == vust_pkg::VUST_OP_XSTATE;
  wire inDirty = upperState == vust_pkg::VUST_DIRTY;
  wire inSaved = upperState == vust_pkg::VUST_SAVED;
  wire startSave = accept && isLegacy && inDirty;
  wire startRestore = accept && isExt && inSaved;
  // a state save or restore leaves the memory image equal to the live uppers;
  // without this snapshot a later restore would bring back a stale image
  wire snapXstate = accept && isXstate;
  wire busy = busyCount != '0;
  wire busyLast = busyCount == CNT_W'(1);
  // a held extended op commits after the restore, so uppers stay coherent
  wire commitNow = accept && !startRestore;
  wire commitHeld = busyLast && !busySave;
  vust_pkg::vust_op_e wOp;
  logic [IDX_W-1:0] wDest;
  logic [HALF_W-1:0] wData;
  assign wOp = commitHeld ? heldOp : (commitNow ? opClass : vust_pkg::VUST_OP_NONE);
  assign wDest = commitHeld ? heldDest : opDest;
  assign wData = commitHeld ? heldData : opUpperData;

  // next tracking state from the transition table
  // only accepted ops move the state; offers during a stall are ignored, not queued
  always_comb begin
    next_state = upperState;
    if (accept) begin
      unique case (1'b1)
        isZero: next_state = vust_pkg::VUST_CLEAN;
        isXstate: next_state = vust_pkg::VUST_SAVED;
        isExt256: next_state = vust_pkg::VUST_DIRTY;
        isExt128: begin
          // from saved the restore leaves it dirty
          next_state = inSaved ? vust_pkg::VUST_DIRTY : vust_pkg::VUST_CLEAN;
        end
        isLegacy: begin
          // clean and saved hold; dirty saves
          next_state = inDirty ? vust_pkg::VUST_SAVED : upperState;
        end
        default: next_state = upperState;
      endcase
    end
  end

  // state and handshake flops
  // penalty is reported when the move ends, so issue can time the stall it saw
  // opReady drops for the whole move; nothing is taken while uppers are in flight
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      upperState <= vust_pkg::VUST_CLEAN;
      opReady <= 1'b1;
      busyCount <= '0;
      busySave <= 1'b0;
      penalty <= 1'b0;
      savePenalty <= 1'b0;
    end else begin
      upperState <= next_state;
      penalty <= busyLast;
      savePenalty <= busyLast && busySave;
      if (startSave || startRestore) begin
        // issue stalls while all uppers move
        busyCount <= startSave ? CNT_W'(SAVE_CYCLES) : CNT_W'(RESTORE_CYCLES);
        busySave <= startSave;
        opReady <= 1'b0;
      end else if (busy) begin
        busyCount <= busyCount - CNT_W'(1);
        opReady <= busyLast;
      end
    end
  end

  // op held across a restore
  // only one op can wait here, since issue is stalled until the restore ends
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      heldOp <= vust_pkg::VUST_OP_NONE;
      heldDest <= '0;
      heldData <= '0;
    end else if (startRestore) begin
      heldOp <= opClass;
      heldDest <= opDest;
      heldData <= opUpperData;
    end
  end

  // upper halves: clear, save, restore and destination writes
  // a clear and a held commit never meet: the clear needs opReady, which is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        upperHalf[i] <= '0;
        savedHalf[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (startSave || snapXstate) begin
          savedHalf[i] <= upperHalf[i];
        end
        if (accept && isZero) begin
          upperHalf[i] <= '0;
        end else if (commitHeld) begin
          // restore all, then apply the held op on its destination
          if (IDX_W'(i) == wDest) begin
            upperHalf[i] <= (wOp == vust_pkg::VUST_OP_EXT256) ? wData : '0;
          end else begin
            upperHalf[i] <= savedHalf[i];
          end
        end else if (IDX_W'(i) == wDest && wOp == vust_pkg::VUST_OP_EXT256) begin
          upperHalf[i] <= wData;
        end else if (IDX_W'(i) == wDest && wOp == vust_pkg::VUST_OP_EXT128) begin
          upperHalf[i] <= '0;
        end
        // legacy ops write nothing here
      end
    end
  end

  // registered upper read port
  // one cycle of latency keeps the wide array mux out of the output path
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdUpper <= '0;
    end else begin
      rdUpper <= upperHalf[rdIndex];
    end
  end

  // two independent lanes share one selector byte
  // no cross-lane path exists: each lane instance sees only its own slice
  logic [HALF_W-1:0] laneLow;
  logic [HALF_W-1:0] laneHigh;
  vust_lane_shuffle #(.ELEM_W(HALF_W / 4)) uLow (
    .srcA(shufSrcA[HALF_W-1:0]),
    .srcB(shufSrcB[HALF_W-1:0]),
    .shuffleImmediate(shuffleImmediate),
    .result(laneLow)
  );
  vust_lane_shuffle #(.ELEM_W(HALF_W / 4)) uHigh (
    .srcA(shufSrcA[2*HALF_W-1:HALF_W]),
    .srcB(shufSrcB[2*HALF_W-1:HALF_W]),
    .shuffleImmediate(shuffleImmediate),
    .result(laneHigh)
  );

  // shuffle result register
  // the result holds until the next request, so a slow reader still finds it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shufDone <= 1'b0;
      shufResult <= '0;
    end else begin
      shufDone <= shufValid;
      if (shufValid) begin
        shufResult <= {laneHigh, laneLow};
      end
    end
  end
endmodule : vust_tracker

/* vust_tracker_props.sv */
// assertion checker for the upper state tracker
`timescale 1ns/1ps
module vust_tracker_props (
  input wire logic clock, // core clock
  input wire logic reset, // async reset
  input wire logic opValid, // offer
  input wire vust_pkg::vust_op_e opClass, // class
  input wire logic opReady, // ready
  input wire logic penalty, // penalty pulse
  input wire logic savePenalty, // save pulse
  input wire vust_pkg::vust_state_e upperState, // state
  input wire logic shufValid, // shuffle request
  input wire logic shufDone // shuffle done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // accepted op and the state it met
  wire take = opValid && opReady;
  wire legacy = take && opClass == vust_pkg::VUST_OP_LEGACY;
  wire wide = take && opClass == vust_pkg::VUST_OP_EXT256;
  wire narrow = take && opClass == vust_pkg::VUST_OP_EXT128;
  wire inSaved = upperState == vust_pkg::VUST_SAVED;
  // eight stalled cycles, then one pulse; a stray pulse would hide a lost copy
  sequence busy_then(bit sv);
    !opReady [*8] ##1 (penalty && opReady && savePenalty == sv);
  endsequence
  a_save_stall: assert property (legacy && upperState == vust_pkg::VUST_DIRTY
    |=> inSaved ##0 busy_then(1)) else $error("save stall wrong");
  a_restore_stall: assert property ((wide || narrow) && inSaved
    |=> upperState == vust_pkg::VUST_DIRTY ##0 busy_then(0)) else $error("restore wrong");
  a_legacy_keep: assert property (legacy && upperState != vust_pkg::VUST_DIRTY
    |=> upperState == $past(upperState) && opReady && !penalty) else $error("legacy moved");
  a_wide_dirty: assert property (wide && !inSaved
    |=> upperState == vust_pkg::VUST_DIRTY && opReady && !penalty) else $error("wide op");
  a_narrow_clean: assert property (narrow && !inSaved
    |=> upperState == vust_pkg::VUST_CLEAN && opReady && !penalty) else $error("narrow op");
  a_clear_fast: assert property (take && opClass == vust_pkg::VUST_OP_ZEROUP
    |=> upperState == vust_pkg::VUST_CLEAN && opReady) else $error("upper clear");
  a_xstate_saved: assert property (take && opClass == vust_pkg::VUST_OP_XSTATE
    |=> inSaved) else $error("state save mark");
  a_shuf_next: assert property (shufValid |=> shufDone) else $error("shuffle late");
  a_pen_cause: assert property (penalty |-> !$past(opReady)) else $error("stray penalty");
endmodule : vust_tracker_props
bind vust_tracker vust_tracker_props vust_tracker_props_inst (.*);

/* vust_issue_model.sv */
// issue-side model offering one instruction at a time
`timescale 1ns/1ps
module vust_issue_model (
  input wire logic clock, // core clock
  input wire logic opReady, // tracker ready
  output logic opValid, // offer
  output vust_pkg::vust_op_e opClass, // class
  output logic [3:0] opDest, // destination
  output logic [127:0] opUpperData // upper data
);
  initial begin
    opValid = 1'b0;
    opClass = vust_pkg::VUST_OP_NONE;
    opDest = 4'h0;
    opUpperData = '0;
  end
  // waits gap edges (slow issue), then holds the offer until ready is seen or 40 edges pass
  task automatic issue(input vust_pkg::vust_op_e c, input logic [3:0] d,
                       input logic [127:0] u, input int gap, output bit ok);
    int n;
    repeat (gap) @(posedge clock);
    opValid <= 1'b1;
    opClass <= c;
    opDest <= d;
    opUpperData <= u;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!opReady && n < 40);
    ok = opReady;
    // released lines show a changed pattern, not the old value
    opValid <= 1'b0;
    opClass <= vust_pkg::VUST_OP_NONE;
    opDest <= ~d;
    opUpperData <= ~u;
  endtask : issue
endmodule : vust_issue_model

/* tb_top.sv */
// self-checking bench for the upper state tracker
`timescale 1ns/1ps
`include "vust_cfg.svh"
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] rdIndex = 4'h0;
  logic shufValid = 1'b0;
  logic [255:0] shufSrcA = '0, shufSrcB = '0, shufResult;
  logic [7:0] shuffleImmediate = 8'h00;
  logic opValid, opReady, penalty, savePenalty, shufDone;
  logic [3:0] opDest;
  logic [127:0] opUpperData, rdUpper;
  vust_pkg::vust_op_e opClass;
  vust_pkg::vust_state_e upperState;
  int failures = 0, samples_checked = 0, seed = 43, st = 0; // st: 0 clean 1 dirty 2 saved
  logic [127:0] up [16]; // model of all upper halves
  always #5 clock = ~clock;
  vust_tracker vust_tracker_inst (.*);
  vust_issue_model vust_issue_model_inst (.*);
  task automatic check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // one instruction through the model; pen 1 save, 2 restore
  task automatic do_op(input int c, input int gap);
    logic [3:0] d;
    logic [127:0] u;
    bit ok;
    int pen;
    d = 4'($random(seed));
    u = {$random(seed), $random(seed), $random(seed), $random(seed)};
    rdIndex <= d;
    pen = 0;
    vust_issue_model_inst.issue(vust_pkg::vust_op_e'(c), d, u, gap, ok);
    check(ok, "offer not taken");
    if (!ok) stop_test();
    case (c)
      1: if (st == 1) begin st = 2; pen = 1; end
      2, 3: begin
        pen = (st == 2) ? 2 : 0;
        st = (c == 2 && st != 2) ? 0 : 1;
        up[d] = (c == 3) ? u : '0;
      end
      4: begin st = 0; foreach (up[i]) up[i] = '0; end
      default: st = 2;
    endcase
    // the pulse stands for the one cycle right after the last busy edge
    repeat (pen == 0 ? 1 : (pen == 1 ? `VUST_SAVE_CYCLES : `VUST_RESTORE_CYCLES)) @(posedge clock);
    #1;
    check(penalty === (pen != 0) && savePenalty === (pen == 1), "penalty");
    // a restore lands its destination at that same edge, so the read port lags one more
    if (pen != 0) begin
      @(posedge clock);
      #1;
    end
    check(upperState === vust_pkg::vust_state_e'(st), "state");
    check(rdUpper === up[d], "upper half");
  endtask : do_op
  initial begin
    // classes: 1 legacy 2 narrow 3 wide 4 clear 5 state save
    int plan [10] = '{3, 1, 1, 3, 2, 3, 4, 1, 5, 2}; // clear after wide code
    logic [255:0] a, b, x;
    int s;
    foreach (up[i]) up[i] = '0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    check(upperState === vust_pkg::VUST_CLEAN && rdUpper === '0, "reset");
    foreach (plan[i]) do_op(plan[i], 1 + i % 3);
    $display("directed walk done");
    for (int i = 0; i < 80; i++) do_op(1 + $unsigned($random(seed)) % 5, 1 + i % 2);
    $display("random mix done");
    for (int k = 0; k < 256; k++) begin
      for (int e = 0; e < 8; e++) begin
        a[e*32+:32] = $random(seed);
        b[e*32+:32] = $random(seed);
      end
      for (int p = 0; p < 8; p++) begin
        s = (p / 4) * 4 + ((k >> (2 * (p % 4))) & 3);
        x[p*32+:32] = (p % 4 < 2) ? a[s*32+:32] : b[s*32+:32];
      end
      @(posedge clock);
      shufSrcA <= a;
      shufSrcB <= b;
      shuffleImmediate <= 8'(k);
      shufValid <= 1'b1;
      @(posedge clock);
      shufValid <= 1'b0;
      #1;
      check(shufDone === 1'b1 && shufResult === x, "shuffle");
    end
    $display("shuffle sweep done");
    stop_test();
  end
endmodule : tb_top
